/* File: hdl/acrb_cfg.svh */
// Summary of operation
// - Test source bit 4: 0 external test signal, 1 internal.
// - Test amplitude bit 2: 0 single amplitude, 1 double.
// - Test frequency: 00 clk/2^21, 01 clk/2^20, 10 unused, 11 dc.
// - Reference/drive bit 6 resets to 1; software always writes 1.
// - Reference buffer bit 7: 0 powered down, 1 enabled.
// - Drive measure bit 4 routes drive input to channels with input code 010.
// - Drive reference bit 3: 0 external, 1 internal mid-supply.
// - Drive buffer bit 2: 0 powered down, 1 enabled.
// - Drive sense bit 1: 0 disabled, 1 enabled.
// - Bit 0 reports drive status: 0 connected, 1 disconnected.
// - Comparator threshold bits 7..5 pick thresholds, reset code 000.
// - Lead-off mode bit 4: 0 current source, 1 resistor pull.
// - Lead-off current bits 3..2 select 6/12/18/24 nA, reset 00.
// - Lead-off frequency bits 1..0: 01 ac, 10 unused, 11 dc; reset 00.
// - Eight channel registers at consecutive offsets; bit 7 powers channel down.
// - Channel bits 6..4 form the gain sent to that channel's amplifier.
// - Channel bits 2..0 select one of eight inputs, reset 000.
// - Two drive sense registers, one bit per channel, bit n-1 for channel n.
`ifndef ACRB_CFG_SVH
`define ACRB_CFG_SVH

// Register word indices; the bus byte address is four times these
`define ACRB_IDX_TEST       5'h02
`define ACRB_IDX_REFDRV     5'h03
`define ACRB_IDX_LEADOFF    5'h04
`define ACRB_IDX_CH_FIRST   5'h05
`define ACRB_IDX_CH_LAST    5'h0C
`define ACRB_IDX_SENSE_POS  5'h0D
`define ACRB_IDX_SENSE_NEG  5'h0E

// Reset values
`define ACRB_RST_TEST       8'h00
`define ACRB_RST_REFDRV     8'h40
`define ACRB_RST_LEADOFF    8'h00
`define ACRB_RST_CH         8'h00
`define ACRB_RST_SENSE      8'h00

// Writable bit masks; reserved bits read zero, except reference/drive bit 6, which reads one
`define ACRB_MASK_TEST      8'h17
`define ACRB_MASK_REFDRV    8'hBE
`define ACRB_MASK_CH        8'hF7

// Field positions
`define ACRB_REFDRV_FIXED   6
`define ACRB_REFDRV_STAT    0
`define ACRB_MUX_DRIVE_MEAS 3'h2

// Test pulse periods as powers of two of the clock
`define ACRB_TEST_DIV_SLOW  21
`define ACRB_TEST_DIV_FAST  20

// AXI responses
`define ACRB_RESP_OKAY      2'h0
`define ACRB_RESP_SLVERR    2'h2

`endif

/* File: hdl/acrb_pkg.sv */
package acrb_pkg;

  typedef struct packed {
    logic       test_internal;
    logic       test_amplitude_double;
    logic [1:0] test_frequency_select;
    logic       test_signal_pulse;
    logic       reference_buffer_on;
    logic       reference_high_level;
    logic       drive_measure_route;
    logic       drive_reference_internal;
    logic       drive_buffer_on;
    logic       drive_sense_enable;
    logic [2:0] comparator_threshold;
    logic       lead_detect_resistor_mode;
    logic [1:0] lead_detect_current;
    logic [1:0] lead_detect_frequency;
    logic [7:0] drive_select_positive_bit;
    logic [7:0] drive_select_negative_bit;
  } acrb_ctrl_t;

  typedef struct packed {
    logic [7:0] power_down;
    logic [7:0] measure_drive;
    logic [23:0] gain;
    logic [23:0] channel_input_select;
  } acrb_chan_t;

  typedef struct packed {
    logic [7:0]      test_cfg;
    logic [7:0]      refdrv_cfg;
    logic [7:0]      leadoff_cfg;
    logic [7:0][7:0] chan_cfg;
    logic [7:0]      sense_pos;
    logic [7:0]      sense_neg;
    logic [20:0]     test_count;
    logic            status_sync1;
    logic            status_sync2;
    logic            awvalid_seen;
    logic [4:0]      aw_index;
    logic            aw_ok;
    logic            wvalid_seen;
    logic [7:0]      w_byte;
    logic            w_lane;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } acrb_state_t;

endpackage

/* File: hdl/acrb_bank.sv */
`timescale 1ns/1ns
`include "acrb_cfg.svh"

module acrb_bank
  import acrb_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Analog status pin, asynchronous
  input  wire logic        drive_disconnected_pin,
  // Drive input for measurement routing
  input  wire logic        drive_input_signal,
  // Controls to analog blocks; static except the test pulse and the gated measure outputs
  output acrb_ctrl_t       ctrl,
  output acrb_chan_t       chan,
  output logic [7:0]       channel_measure_signal
);

  // Whole module state in one packed word
  acrb_state_t s;
  acrb_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Decode a byte address; returns 1 when a register lives there
  function automatic logic addr_mapped(input logic [31:0] addr);
    logic [4:0] idx;
    idx = addr[6:2];
    // Upper bits must be zero; aliased copies would only confuse software
    if (addr[31:7] != 25'h0000000)
    begin
      addr_mapped = 1'b0;
    end
    else if (idx == `ACRB_IDX_TEST || idx == `ACRB_IDX_REFDRV || idx == `ACRB_IDX_LEADOFF)
    begin
      addr_mapped = 1'b1;
    end
    else if (idx >= `ACRB_IDX_CH_FIRST && idx <= `ACRB_IDX_CH_LAST)
    begin
      addr_mapped = 1'b1;
    end
    else if (idx == `ACRB_IDX_SENSE_POS || idx == `ACRB_IDX_SENSE_NEG)
    begin
      addr_mapped = 1'b1;
    end
    else
    begin
      addr_mapped = 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, live status folded into the reference/drive word
  function automatic logic [7:0] read_reg(input acrb_state_t st, input logic [4:0] idx);
    logic [2:0] ch;
    // Channel offset; only meaningful inside the channel range
    ch = 3'(idx - `ACRB_IDX_CH_FIRST);
    if (idx == `ACRB_IDX_TEST)
    begin
      read_reg = st.test_cfg;
    end
    else if (idx == `ACRB_IDX_REFDRV)
    begin
      // Bit 0 is never stored; it shows the synchronised pin
      read_reg = {st.refdrv_cfg[7:1], st.status_sync2};
    end
    else if (idx == `ACRB_IDX_LEADOFF)
    begin
      read_reg = st.leadoff_cfg;
    end
    else if (idx >= `ACRB_IDX_CH_FIRST && idx <= `ACRB_IDX_CH_LAST)
    begin
      read_reg = st.chan_cfg[ch];
    end
    else if (idx == `ACRB_IDX_SENSE_POS)
    begin
      read_reg = st.sense_pos;
    end
    else if (idx == `ACRB_IDX_SENSE_NEG)
    begin
      read_reg = st.sense_neg;
    end
    else
    begin
      read_reg = 8'h00;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Handshake outputs; one write and one read in flight at most
  // Write side: each half is refused while parked or while the answer waits
  assign s_axi_awready = !s.awvalid_seen && !s.bvalid;
  assign s_axi_wready  = !s.wvalid_seen && !s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;

  // Read side: a new address waits until the last data is taken
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic       aw_now;
    logic       w_now;
    logic [4:0] widx;
    logic       wok;
    logic [7:0] wb;
    logic [2:0] wch;
    aw_now = 1'b0;
    w_now  = 1'b0;
    widx   = 5'h00;
    wok    = 1'b0;
    wb     = 8'h00;
    wch    = 3'h0;
    next_s = s;

    // Status pin passes two flops before any use
    // The first flop may go metastable; only the second is ever read
    next_s.status_sync1 = drive_disconnected_pin;
    next_s.status_sync2 = s.status_sync1;

    // Free-running divider for the internal test pulse
    // It restarts from zero at every reset, so the first slow edge is far off
    next_s.test_count = 21'(s.test_count + 21'h000001);

    // Catch address and data in either order
    // Each half parks in the state until its partner arrives
    aw_now = s_axi_awvalid && s_axi_awready;
    w_now  = s_axi_wvalid && s_axi_wready;
    if (aw_now)
    begin
      next_s.awvalid_seen = 1'b1;
      next_s.aw_index     = s_axi_awaddr[6:2];
      next_s.aw_ok        = addr_mapped(s_axi_awaddr);
    end
    if (w_now)
    begin
      next_s.wvalid_seen = 1'b1;
      next_s.w_byte      = s_axi_wdata[7:0];
      next_s.w_lane      = s_axi_wstrb[0];
    end

    // Commit once both halves are held
    // The response rises one cycle after the later half is parked
    if (s.awvalid_seen && s.wvalid_seen)
    begin
      widx = s.aw_index;
      wok  = s.aw_ok;
      wb   = s.w_byte;
      wch  = 3'(widx - `ACRB_IDX_CH_FIRST);
      next_s.awvalid_seen = 1'b0;
      next_s.wvalid_seen  = 1'b0;
      next_s.bvalid       = 1'b1;
      next_s.bresp        = wok ? `ACRB_RESP_OKAY : `ACRB_RESP_SLVERR;
      // Only lane 0 holds data; writes with it off change nothing
      // Unmapped places answer with an error and change nothing either
      if (wok && s.w_lane)
      begin
        if (widx == `ACRB_IDX_TEST)
        begin
          next_s.test_cfg = wb & `ACRB_MASK_TEST;
        end
        else if (widx == `ACRB_IDX_REFDRV)
        begin
          next_s.refdrv_cfg = (wb & `ACRB_MASK_REFDRV) | `ACRB_RST_REFDRV;
        end
        else if (widx == `ACRB_IDX_LEADOFF)
        begin
          next_s.leadoff_cfg = wb;
        end
        else if (widx >= `ACRB_IDX_CH_FIRST && widx <= `ACRB_IDX_CH_LAST)
        begin
          next_s.chan_cfg[wch] = wb & `ACRB_MASK_CH;
        end
        else if (widx == `ACRB_IDX_SENSE_POS)
        begin
          next_s.sense_pos = wb;
        end
        else
        begin
          next_s.sense_neg = wb;
        end
      end
    end

    // The answer drops at the edge that sees its ready
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken
    // Data comes from the state before this edge, so a write committing
    // in the same cycle shows up only in the next read
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid)
    begin
      next_s.rvalid = 1'b1;
      if (addr_mapped(s_axi_araddr))
      begin
        next_s.rdata = {24'h000000, read_reg(s, s_axi_araddr[6:2])};
        next_s.rresp = `ACRB_RESP_OKAY;
      end
      // Unmapped reads return zero with an error
      else
      begin
        next_s.rdata = 32'h00000000;
        next_s.rresp = `ACRB_RESP_SLVERR;
      end
    end

    // Synchronous reset to documented defaults; it overrides every update above
    if (!rst_n)
    begin
      next_s = '0;
      // Configuration words
      next_s.test_cfg    = `ACRB_RST_TEST;
      next_s.refdrv_cfg  = `ACRB_RST_REFDRV;
      next_s.leadoff_cfg = `ACRB_RST_LEADOFF;
      for (int i = 0; i < 8; i++)
      begin
        next_s.chan_cfg[i] = `ACRB_RST_CH;
      end
      next_s.sense_pos   = `ACRB_RST_SENSE;
      next_s.sense_neg   = `ACRB_RST_SENSE;
      // Bus side idles: nothing parked, nothing answered, ready high
      next_s.awvalid_seen = 1'b0;
      next_s.wvalid_seen  = 1'b0;
      next_s.bvalid       = 1'b0;
      next_s.bresp        = `ACRB_RESP_OKAY;
      next_s.rvalid       = 1'b0;
      next_s.rdata        = 32'h00000000;
      next_s.rresp        = `ACRB_RESP_OKAY;
      // Divider and synchroniser restart from a known low level
      next_s.test_count   = 21'h0;
      next_s.status_sync1 = 1'b0;
      next_s.status_sync2 = 1'b0;
    end
  end

  // Registered state
  always_ff @(posedge core_clk)
  begin
    s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test signal shaping; the unused code 10 idles low
  // Codes 00 and 01 need 2^20 and 2^19 clocks before their first edge
  logic test_pulse;
  always_comb
  begin
    case (s.test_cfg[1:0])
      2'h0:    test_pulse = s.test_count[`ACRB_TEST_DIV_SLOW - 1];
      2'h1:    test_pulse = s.test_count[`ACRB_TEST_DIV_FAST - 1];
      2'h3:    test_pulse = 1'b1;
      default: test_pulse = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields straight from the stored words
  // The test pulse is the only field that is not a stored bit
  always_comb
  begin
    // Test signal setup
    ctrl.test_internal             = s.test_cfg[4];
    ctrl.test_amplitude_double     = s.test_cfg[2];
    ctrl.test_frequency_select     = s.test_cfg[1:0];
    ctrl.test_signal_pulse         = test_pulse;

    // Reference and drive setup
    ctrl.reference_buffer_on       = s.refdrv_cfg[7];
    ctrl.reference_high_level      = s.refdrv_cfg[5];
    ctrl.drive_measure_route       = s.refdrv_cfg[4];
    ctrl.drive_reference_internal  = s.refdrv_cfg[3];
    ctrl.drive_buffer_on           = s.refdrv_cfg[2];
    ctrl.drive_sense_enable        = s.refdrv_cfg[1];

    // Lead-off detection
    ctrl.comparator_threshold      = s.leadoff_cfg[7:5];
    ctrl.lead_detect_resistor_mode = s.leadoff_cfg[4];
    ctrl.lead_detect_current       = s.leadoff_cfg[3:2];
    ctrl.lead_detect_frequency     = s.leadoff_cfg[1:0];

    // Drive derivation picks, one bit per channel
    ctrl.drive_select_positive_bit = s.sense_pos;
    ctrl.drive_select_negative_bit = s.sense_neg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel fields and drive measurement routing
  generate
    for (genvar g = 0; g < 8; g++)
    begin : g_chan
      // Stored fields, one slice per channel
      assign chan.power_down[g]                   = s.chan_cfg[g][7];
      assign chan.gain[3*g +: 3]                  = s.chan_cfg[g][6:4];
      assign chan.channel_input_select[3*g +: 3]  = s.chan_cfg[g][2:0];

      // Routing needs both the global bit and this channel's input code
      assign chan.measure_drive[g] = s.refdrv_cfg[4] &&
                                     (s.chan_cfg[g][2:0] == `ACRB_MUX_DRIVE_MEAS);
      // Gated copy so an open route presents a quiet level
      assign channel_measure_signal[g] = chan.measure_drive[g] & drive_input_signal;
    end
  endgenerate

endmodule

/* File: test/acrb_bank_props.sv */
`timescale 1ns/1ns
module acrb_bank_props
  import acrb_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Analog side
  input wire logic       drive_input_signal,
  input acrb_ctrl_t      ctrl,
  input acrb_chan_t      chan,
  input wire logic [7:0] channel_measure_signal
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] exp_meas;
  ////////////////////////////////////////////////////////////////
  // Channels that should see the drive input
  always_comb
  begin
    for (int g = 0; g < 8; g++)
      exp_meas[g] = ctrl.drive_measure_route && (chan.channel_input_select[3*g+:3] == 3'h2);
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////////
  write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  measure_route_a: assert property (chan.measure_drive == exp_meas)
    else $error("measure routing wrong");
  measure_out_a: assert property (channel_measure_signal == (chan.measure_drive & {8{drive_input_signal}}))
    else $error("measure output wrong");
  test_dc_a: assert property (ctrl.test_frequency_select == 2'h3 |-> ctrl.test_signal_pulse)
    else $error("dc test level not high");
  test_unused_a: assert property (ctrl.test_frequency_select == 2'h2 |-> !ctrl.test_signal_pulse)
    else $error("unused test code pulses");
endmodule

bind acrb_bank acrb_bank_props u_acrb_bank_props (.core_clk(core_clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .drive_input_signal(drive_input_signal), .ctrl(ctrl), .chan(chan),
  .channel_measure_signal(channel_measure_signal));

/* File: test/acrb_bank_tb_top.sv */
`timescale 1ns/1ns
module acrb_bank_tb_top
  import acrb_pkg::*;
;
  logic        core_clk, rst_n, awv, wv, bry, arv, rry, pin, din, awr, wr, bv, arr, rv;
  logic [31:0] awa, wd, ara, rd;
  logic [3:0]  ws;
  logic [2:0]  awp, arp;
  logic [1:0]  br, rr;
  acrb_ctrl_t  ctrl;
  acrb_chan_t  chan;
  logic [7:0]  meas;
  logic [7:0]  mdl [16];
  int          errors, total_checks, i;
  logic [7:0]  d;
  logic [3:0]  s;

  always #2 core_clk = ~core_clk;

  acrb_bank u_acrb_bank (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(awp), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(arp), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .drive_disconnected_pin(pin), .drive_input_signal(din),
    .ctrl(ctrl), .chan(chan), .channel_measure_signal(meas));
  ////////////////////////////////////////////////////////////////
  // Verdict and compare helpers
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // One bus transfer; ready is raised at random to stall the answer
  task bus(input logic w_en, input logic [4:0] idx, input logic [7:0] v, input logic [3:0] st);
    int n;
    logic a, w, b, m;
    logic [31:0] r;
    @(posedge core_clk);
    r = $urandom;
    m = idx inside {[2:14]};
    a = 1;
    w = w_en;
    b = 0;
    awv <= w_en;
    wv <= w_en;
    arv <= !w_en;
    awa <= {25'h0, idx, 2'h0};
    ara <= {25'h0, idx, 2'h0};
    wd <= {r[31:8], v};
    ws <= st;
    awp <= r[2:0];
    arp <= r[5:3];
    for (n = 0; n < 40; n++)
    begin
      @(posedge core_clk);
      if (!a && !w && b && (w_en ? bv : rv))
        break;
      if (a && (w_en ? awr : arr))
      begin
        a = 0;
        awv <= 0;
        arv <= 0;
      end
      if (w && wr)
      begin
        w = 0;
        wv <= 0;
      end
      b = b | r[n % 32];
      bry <= b & w_en;
      rry <= b & !w_en;
    end
    bry <= 0;
    rry <= 0;
    if (n >= 40)
    begin
      errors++;
      stop_test;
    end
    if (w_en)
    begin
      chk(br, m ? 2'h0 : 2'h2);
      // Reserved bits obey the fixed values even if software slips
      if (m && st[0])
        mdl[idx] = idx == 2 ? v & 8'h17 : idx == 3 ? (v & 8'hBE) | 8'h40 : idx inside {[5:12]} ? v & 8'hF7 : v;
    end
    else
      chk({rr, rd}, m ? {2'h0, 24'h0, mdl[idx] | ((idx == 3) ? {7'h0, pin} : 8'h0)} : {2'h2, 32'h0});
  endtask
  ////////////////////////////////////////////////////////////////
  // Expected analog controls from the shadow copy
  task chk_out;
    acrb_ctrl_t e;
    acrb_chan_t c;
    #1;
    e = {mdl[2][4], mdl[2][2], mdl[2][1:0], mdl[2][1:0] == 2'h3, mdl[3][7], mdl[3][5], mdl[3][4:1],
         mdl[4], mdl[13], mdl[14]};
    for (int g = 0; g < 8; g++)
    begin
      c.power_down[g] = mdl[5+g][7];
      c.measure_drive[g] = mdl[3][4] && mdl[5+g][2:0] == 3'h2;
      c.gain[3*g+:3] = mdl[5+g][6:4];
      c.channel_input_select[3*g+:3] = mdl[5+g][2:0];
    end
    chk(ctrl, e);
    chk(chan, c);
    chk(meas, c.measure_drive & {8{din}});
  endtask
  // Reset, then every register and the controls must show defaults
  task rst_chk;
    rst_n <= 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    foreach (mdl[k])
      mdl[k] = 8'h00;
    mdl[3] = 8'h40;
    for (int k = 0; k < 16; k++)
      bus(0, k[4:0], 8'h00, 4'h0);
    chk_out;
    $display("test reset done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {core_clk, awv, wv, bry, arv, rry, pin, din, ws, awp, arp} = '0;
    {awa, wd, ara} = '0;
    void'($urandom(87520));
    rst_chk;
    // Random traffic; software keeps reserved bits as required
    // Lead-off sense selects live outside this bank, so any frequency code is legal
    repeat (80)
    begin
      i = $urandom_range(2, 14);
      d = 8'($urandom);
      d = i == 2 ? d & 8'h17 : i == 3 ? (d & 8'hBE) | 8'h40 : (i > 4 && i < 13) ? d & 8'hF7 : d;
      s = 4'($urandom);
      s[0] = s[0] | s[1];
      bus(1, i[4:0], d, s);
      din <= 1'($urandom);
      chk_out;
      bus(0, i[4:0], 8'h00, 4'h0);
    end
    $display("test random done");
    // All test frequency codes
    for (int f = 0; f < 4; f++)
    begin
      bus(1, 5'h02, {mdl[2][7:2], f[1:0]}, 4'hF);
      chk_out;
    end
    $display("test frequency done");
    // Every input code once, measure routing on
    for (int g = 0; g < 8; g++)
      bus(1, 5'h05 + g[4:0], {g[0], g[2:0], 1'b0, g[2:0]}, 4'hF);
    bus(1, 5'h03, 8'h50, 4'hF);
    din <= 1;
    chk_out;
    $display("test channels done");
    // Unmapped places and a write with the low lane off
    bus(1, 5'h00, 8'hFF, 4'hF);
    bus(1, 5'h01, 8'hFF, 4'hF);
    bus(1, 5'h0F, 8'hFF, 4'hF);
    bus(1, 5'h04, 8'hAA, 4'hE);
    bus(0, 5'h04, 8'h00, 4'h0);
    chk_out;
    $display("test refusals done");
    // Drive status pin through the synchroniser
    pin <= 1;
    repeat (3) @(posedge core_clk);
    bus(0, 5'h03, 8'h00, 4'h0);
    pin <= 0;
    repeat (3) @(posedge core_clk);
    bus(0, 5'h03, 8'h00, 4'h0);
    $display("test status done");
    rst_chk;
    stop_test;
  end
endmodule
